// ---- hdl/disp_cmd_consts.vh ----
// Contract
// RULE1 - command 28h, no parameters, blanks panel: frame memory output off, blank page shown
// RULE2 - command 29h, no parameters, unblanks panel: frame memory output enabled again
// RULE3 - blank and unblank touch only the output enable, nothing else
// RULE4 - blank while blanked, or unblank while unblanked, is a no-operation
// RULE5 - after any reset the panel output starts blanked until unblank arrives
// RULE6 - command 2Ah plus four bytes sets 16-bit first and last column, high first
// RULE7 - hardware reset column bounds 0000h and 00EFh; setting them changes nothing else
// RULE8 - software reset last column 00EFh, or 013Fh when row/column exchange set
// RULE9 - host keeps first column <= last column and first row <= last row
// RULE10 - pixels beyond maximum column 239/319 or row 319/239 are ignored
// RULE11 - stored bounds latched as active window when memory write arrives
// RULE12 - command 2Bh plus four bytes sets first and last row; reset 0000h, 013Fh
// RULE13 - software reset last row 013Fh, or 00EFh when row/column exchange set
// RULE14 - command 2Ch starts pixel burst and reloads counters to window start
// RULE15 - window start corner follows memory access control orientation
// RULE16 - any command byte ends an ongoing write burst, then is processed
// RULE17 - resets never alter frame memory contents
// RULE18 - column advances per pixel, wraps to next row, window wraps after last row
`ifndef DISP_CMD_CONSTS_VH
`define DISP_CMD_CONSTS_VH

// ****************************************
// command codes
// ****************************************
`define CMD_PANEL_BLANK     8'h28
`define CMD_PANEL_UNBLANK   8'h29
`define CMD_COLUMN_WINDOW   8'h2a
`define CMD_ROW_WINDOW      8'h2b
`define CMD_MEMORY_WRITE    8'h2c

// ****************************************
// reset values and limits
// ****************************************
`define FIRST_BOUND_RST     16'h0000
`define SHORT_AXIS_LAST     16'h00ef
`define LONG_AXIS_LAST      16'h013f
`define WINDOW_PARAM_LAST   2'h3

`endif

// ---- hdl/window_addr_counter.v ----
`timescale 1ns/10ps
module window_addr_counter #(
    parameter AW = 16
) (
    input  wire          i_sys_clk,
    input  wire          i_rst_n,
    input  wire          i_load,
    input  wire          i_step,
    input  wire [AW-1:0] i_first_column,
    input  wire [AW-1:0] i_last_column,
    input  wire [AW-1:0] i_first_row,
    input  wire [AW-1:0] i_last_row,
    input  wire          i_column_down,
    input  wire          i_row_down,
    output reg  [AW-1:0] o_column,
    output reg  [AW-1:0] o_row
);

// ****************************************
// active window, latched at burst start
// ****************************************
reg  [AW-1:0] col_start;
reg  [AW-1:0] col_end;
reg  [AW-1:0] row_start;
reg  [AW-1:0] row_end;
reg           col_dn;
reg           row_dn;
localparam [AW-1:0] STEP = {{(AW-1){1'b0}}, 1'b1};
wire [AW-1:0] col_next = col_dn ? o_column - STEP : o_column + STEP;
wire [AW-1:0] row_next = row_dn ? o_row - STEP : o_row + STEP;

always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        col_start <= {AW{1'b0}};
        col_end   <= {AW{1'b0}};
        row_start <= {AW{1'b0}};
        row_end   <= {AW{1'b0}};
        col_dn    <= 1'b0;
        row_dn    <= 1'b0;
        o_column  <= {AW{1'b0}};
        o_row     <= {AW{1'b0}};
    end else if (i_load) begin
        // RULE11 latch active window
        col_dn    <= i_column_down;
        row_dn    <= i_row_down;
        // RULE15 orientation picks corner
        col_start <= i_column_down ? i_last_column : i_first_column;
        col_end   <= i_column_down ? i_first_column : i_last_column;
        row_start <= i_row_down ? i_last_row : i_first_row;
        row_end   <= i_row_down ? i_first_row : i_last_row;
        // RULE14 reload to start
        o_column  <= i_column_down ? i_last_column : i_first_column;
        o_row     <= i_row_down ? i_last_row : i_first_row;
    end else if (i_step) begin
        // RULE18 raster advance with wrap
        if (o_column == col_end) begin
            o_column <= col_start;
            o_row    <= (o_row == row_end) ? row_start : row_next;
        end else begin
            o_column <= col_next;
        end
    end
end

endmodule

// ---- hdl/display_window_write_commands.v ----
`timescale 1ns/10ps
`include "disp_cmd_consts.vh"
module display_window_write_commands #(
    parameter DATA_W = 18,
    parameter AW     = 16
) (
    input  wire              i_sys_clk,
    input  wire              i_arst_n,
    input  wire              i_sw_reset,
    input  wire              i_wr_valid,
    input  wire              i_wr_is_data,
    input  wire [DATA_W-1:0] i_wr_data,
    input  wire              i_row_column_exchange,
    input  wire              i_column_order,
    input  wire              i_row_order,
    output reg               o_panel_output_enable,
    output reg  [AW-1:0]     o_window_first_column,
    output reg  [AW-1:0]     o_window_last_column,
    output reg  [AW-1:0]     o_window_first_row,
    output reg  [AW-1:0]     o_window_last_row,
    output reg               o_write_active,
    output reg               o_mem_we,
    output reg  [AW-1:0]     o_mem_column,
    output reg  [AW-1:0]     o_mem_row,
    output reg  [DATA_W-1:0] o_mem_data
);

// ****************************************
// reset release
// ****************************************
// assert is async, release is through two flops so no
// flop sees a release close to a clock edge
reg rst_meta;
reg rst_n;

always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        rst_meta <= 1'b0;
        rst_n    <= 1'b0;
    end else begin
        rst_meta <= 1'b1;
        rst_n    <= rst_meta;
    end
end

// ****************************************
// interpreter states
// ****************************************
localparam ST_IDLE  = 2'd0;
localparam ST_COLS  = 2'd1;
localparam ST_ROWS  = 2'd2;
localparam ST_WRITE = 2'd3;

// ****************************************
// address limits
// ****************************************
// limits follow the live exchange bit, not its value at burst start
localparam [AW-1:0] COL_MAX_NORMAL = `SHORT_AXIS_LAST;
localparam [AW-1:0] COL_MAX_SWAP   = `LONG_AXIS_LAST;
localparam [AW-1:0] ROW_MAX_NORMAL = `LONG_AXIS_LAST;
localparam [AW-1:0] ROW_MAX_SWAP   = `SHORT_AXIS_LAST;

reg  [1:0]    state;
reg  [1:0]    next_state;
reg  [1:0]    param_idx;
reg  [1:0]    next_param_idx;
reg  [7:0]    shadow_0;
reg  [7:0]    shadow_1;
reg  [7:0]    shadow_2;

wire          take_cmd  = i_wr_valid & ~i_wr_is_data;
wire          take_data = i_wr_valid & i_wr_is_data;
wire [7:0]    cmd_byte  = i_wr_data[7:0];
wire          last_param = (param_idx == `WINDOW_PARAM_LAST);
wire [AW-1:0] param_first = {shadow_0, shadow_1};
wire [AW-1:0] param_last  = {shadow_2, cmd_byte};

// ****************************************
// command decode
// ****************************************
// a software reset in the same cycle outranks every strobe below except at the shadow bytes and the payload registers;
// reset branches or ~i_sw_reset gating sit above the other uses
wire          pixel_beat     = take_data & (state == ST_WRITE);
wire          burst_load     = take_cmd & (cmd_byte == `CMD_MEMORY_WRITE);
wire          param_beat     = take_data & ((state == ST_COLS) | (state == ST_ROWS));
wire          commit_columns = param_beat & last_param & (state == ST_COLS);
wire          commit_rows    = param_beat & last_param & (state == ST_ROWS);

// ****************************************
// next state
// ****************************************
always @* begin
    next_state     = state;
    next_param_idx = param_idx;
    if (i_sw_reset) begin
        next_state     = ST_IDLE;
        next_param_idx = 2'd0;
    end else if (take_cmd) begin
        // RULE16 any command ends burst
        next_param_idx = 2'd0;
        case (cmd_byte)
            `CMD_COLUMN_WINDOW: begin
                next_state = ST_COLS;
            end
            `CMD_ROW_WINDOW: begin
                next_state = ST_ROWS;
            end
            `CMD_MEMORY_WRITE: begin
                next_state = ST_WRITE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end else if (take_data) begin
        case (state)
            ST_COLS, ST_ROWS: begin
                if (last_param) begin
                    next_state     = ST_IDLE;
                    next_param_idx = 2'd0;
                end else begin
                    next_param_idx = param_idx + 2'd1;
                end
            end
            default: begin
                next_state = state;
            end
        endcase
    end
end

always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        state     <= ST_IDLE;
        param_idx <= 2'd0;
    end else begin
        state     <= next_state;
        param_idx <= next_param_idx;
    end
end

// ****************************************
// parameter bytes
// ****************************************
// bytes are held until the fourth arrives, so an interrupted
// sequence leaves the old bounds intact
always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        shadow_0 <= 8'h00;
        shadow_1 <= 8'h00;
        shadow_2 <= 8'h00;
    end else if (param_beat) begin
        case (param_idx)
            2'd0: begin
                shadow_0 <= cmd_byte;
            end
            2'd1: begin
                shadow_1 <= cmd_byte;
            end
            2'd2: begin
                shadow_2 <= cmd_byte;
            end
            default: begin
                shadow_2 <= shadow_2;
            end
        endcase
    end
end

// ****************************************
// column bounds
// ****************************************
always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        // RULE7 column power-on defaults
        o_window_first_column <= `FIRST_BOUND_RST;
        o_window_last_column  <= `SHORT_AXIS_LAST;
    end else if (i_sw_reset) begin
        o_window_first_column <= `FIRST_BOUND_RST;
        // RULE8 last column follows exchange
        o_window_last_column  <= i_row_column_exchange ? `LONG_AXIS_LAST : `SHORT_AXIS_LAST;
    end else if (commit_columns) begin
        // RULE6 commit column bounds
        o_window_first_column <= param_first;
        o_window_last_column  <= param_last;
    end
end

// ****************************************
// row bounds
// ****************************************
always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        // RULE12 row power-on defaults
        o_window_first_row <= `FIRST_BOUND_RST;
        o_window_last_row  <= `LONG_AXIS_LAST;
    end else if (i_sw_reset) begin
        o_window_first_row <= `FIRST_BOUND_RST;
        // RULE13 last row follows exchange
        o_window_last_row  <= i_row_column_exchange ? `SHORT_AXIS_LAST : `LONG_AXIS_LAST;
    end else if (commit_rows) begin
        // RULE12 commit row bounds
        o_window_first_row <= param_first;
        o_window_last_row  <= param_last;
    end
end

// ****************************************
// panel output enable
// ****************************************
always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        // RULE5 blanked after reset
        o_panel_output_enable <= 1'b0;
    end else if (i_sw_reset) begin
        o_panel_output_enable <= 1'b0;
    end else if (take_cmd) begin
        // RULE1 blank the panel
        // RULE4 repeat leaves same value
        if (cmd_byte == `CMD_PANEL_BLANK) begin
            o_panel_output_enable <= 1'b0;
        end
        // RULE2 unblank the panel
        // RULE3 nothing else touched
        if (cmd_byte == `CMD_PANEL_UNBLANK) begin
            o_panel_output_enable <= 1'b1;
        end
    end
end

// ****************************************
// write burst addressing
// ****************************************
wire [AW-1:0] cnt_column;
wire [AW-1:0] cnt_row;

// a software reset in the same cycle freezes the counter
// RULE14 reload on memory write
window_addr_counter #(
    .AW (AW)
) u_addr (
    .i_sys_clk      (i_sys_clk),
    .i_rst_n        (rst_n),
    .i_load         (burst_load & ~i_sw_reset),
    .i_step         (pixel_beat & ~i_sw_reset),
    .i_first_column (o_window_first_column),
    .i_last_column  (o_window_last_column),
    .i_first_row    (o_window_first_row),
    .i_last_row     (o_window_last_row),
    .i_column_down  (i_column_order),
    .i_row_down     (i_row_order),
    .o_column       (cnt_column),
    .o_row          (cnt_row)
);

// ****************************************
// address range check
// ****************************************
// the counter steps over dropped pixels too, so the raster
// keeps its shape when the window hangs past the edge
// RULE10 range depends on exchange
wire [AW-1:0] col_max  = i_row_column_exchange ? COL_MAX_SWAP : COL_MAX_NORMAL;
wire [AW-1:0] row_max  = i_row_column_exchange ? ROW_MAX_SWAP : ROW_MAX_NORMAL;
wire          col_ok   = (cnt_column <= col_max);
wire          row_ok   = (cnt_row <= row_max);
wire          in_range = col_ok & row_ok;

// ****************************************
// frame memory port
// ****************************************
// memory itself sits outside; a strobe is the only way to
// change it, and resets hold the strobe low
always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        // RULE17 no write under reset
        o_mem_we       <= 1'b0;
        o_write_active <= 1'b0;
    end else begin
        // RULE10 drop out-of-range pixels
        // RULE17 soft reset writes nothing
        o_mem_we       <= pixel_beat & in_range & ~i_sw_reset;
        // flag tracks the next state so it rises with the counter reload
        o_write_active <= (next_state == ST_WRITE);
    end
end

// ****************************************
// frame memory payload
// ****************************************
// address and data follow every beat; only the strobe above
// decides whether the memory takes them
always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        o_mem_column <= {AW{1'b0}};
        o_mem_row    <= {AW{1'b0}};
        o_mem_data   <= {DATA_W{1'b0}};
    end else if (pixel_beat) begin
        o_mem_column <= cnt_column;
        o_mem_row    <= cnt_row;
        o_mem_data   <= i_wr_data;
    end
end

endmodule

// ---- verification/display_window_write_commands_checker.sv ----
`timescale 1ns/10ps
module disp_win_checker #(
    parameter DATA_W = 18,
    parameter AW     = 16
) (
    input  wire              i_sys_clk,
    input  wire              i_arst_n,
    input  wire              i_sw_reset,
    input  wire              i_wr_valid,
    input  wire              i_wr_is_data,
    input  wire [DATA_W-1:0] i_wr_data,
    input  wire              i_row_column_exchange,
    input  wire              o_panel_output_enable,
    input  wire [AW-1:0]     o_window_last_column,
    input  wire [AW-1:0]     o_window_last_row,
    input  wire              o_write_active,
    input  wire              o_mem_we,
    input  wire [AW-1:0]     o_mem_column,
    input  wire [AW-1:0]     o_mem_row,
    input  wire [DATA_W-1:0] o_mem_data
);
    // ****************************************
    // command stream properties
    // ****************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    // a software reset in the same cycle swallows the item
    wire       cmd  = i_wr_valid && !i_wr_is_data && !i_sw_reset;
    wire [7:0] code = i_wr_data[7:0];
    wire       flip = cmd && (code == 8'h28 || code == 8'h29);

    a_blank_turns_off: assert property (cmd && code == 8'h28 |=> !o_panel_output_enable)
        else $error("blank command left the output on");
    a_unblank_turns_on: assert property (cmd && code == 8'h29 |=> o_panel_output_enable)
        else $error("unblank command left the output off");
    a_enable_has_cause: assert property ($changed(o_panel_output_enable) |-> $past(flip) || $past(i_sw_reset))
        else $error("output enable moved without a cause");
    a_blank_keeps_window: assert property (flip |=> $stable(o_window_last_column) && $stable(o_window_last_row))
        else $error("blank or unblank moved the window");
    a_sw_reset_bounds: assert property (i_sw_reset |=> !o_panel_output_enable && !o_write_active
        && o_window_last_column == ($past(i_row_column_exchange) ? 16'h013f : 16'h00ef)
        && o_window_last_row == ($past(i_row_column_exchange) ? 16'h00ef : 16'h013f))
        else $error("software reset values wrong");
    a_burst_starts: assert property (cmd && code == 8'h2c |=> o_write_active)
        else $error("memory write did not start a burst");
    a_cmd_ends_burst: assert property (cmd && code != 8'h2c |=> !o_write_active)
        else $error("command did not end the burst");
    a_we_from_beat: assert property (o_mem_we |-> $past(i_wr_valid && i_wr_is_data && o_write_active)
        && o_mem_data == $past(i_wr_data))
        else $error("pixel write without a matching data beat");
    a_range_limit: assert property (o_mem_we |-> o_mem_column <= ($past(i_row_column_exchange) ? 16'd319 : 16'd239)
        && o_mem_row <= ($past(i_row_column_exchange) ? 16'd239 : 16'd319))
        else $error("pixel written outside the memory range");

    c_pixel_written: cover property (o_mem_we);
    c_sw_reset_seen: cover property (i_sw_reset ##1 !i_sw_reset);
    c_unblank_seen: cover property (cmd && code == 8'h29);
endmodule

bind display_window_write_commands disp_win_checker #(
    .DATA_W(DATA_W),
    .AW    (AW)
) i_disp_win_checker (
    .i_sys_clk, .i_arst_n, .i_sw_reset, .i_wr_valid, .i_wr_is_data, .i_wr_data, .i_row_column_exchange,
    .o_panel_output_enable, .o_window_last_column, .o_window_last_row, .o_write_active,
    .o_mem_we, .o_mem_column, .o_mem_row, .o_mem_data
);

// ---- verification/host_cmd_model.sv ----
`timescale 1ns/10ps
module host_cmd_model #(
    parameter DATA_W = 18
) (
    input  wire              i_sys_clk,
    output reg               o_valid,
    output reg               o_is_data,
    output reg  [DATA_W-1:0] o_data
);
    // ****************************************
    // host side of the command stream
    // ****************************************
    initial begin
        o_valid   = 1'b0;
        o_is_data = 1'b0;
        o_data    = {DATA_W{1'b0}};
    end
    // one item a cycle
    // no ready exists, so each call owns exactly one taking edge
    task put(input logic is_data, input logic [DATA_W-1:0] d);
        o_valid   = 1'b1;
        o_is_data = is_data;
        o_data    = d;
        @(posedge i_sys_clk);
        #1;
    endtask
    // released lines must not keep showing the old value
    task idle;
        o_valid = 1'b0;
        o_data  = ~o_data;
        @(posedge i_sys_clk);
        #1;
    endtask
    task window(input logic [7:0] code, input logic [15:0] first, input logic [15:0] last);
        put(1'b0, {10'h000, code});
        put(1'b1, {10'h000, first[15:8]});
        put(1'b1, {10'h000, first[7:0]});
        put(1'b1, {10'h000, last[15:8]});
        put(1'b1, {10'h000, last[7:0]});
    endtask
endmodule

// ---- verification/tb_display_window_write_commands.sv ----
`timescale 1ns/10ps
module tb_display_window_write_commands;
    logic        i_sys_clk           = 1'b0;
    logic        i_arst_n            = 1'b0;
    logic        sw_reset            = 1'b0;
    logic        row_column_exchange = 1'b0;
    logic        column_order        = 1'b0;
    logic        row_order           = 1'b0;
    wire         valid, is_data, enable, active, we;
    wire  [17:0] wr_data, mem_data;
    wire  [15:0] first_col, last_col, first_row, last_row, mem_col, mem_row;
    int          errors              = 0;
    int          n_checks            = 0;
    localparam logic [47:0] BLANK_SEQ = 48'h2929_2828_2928;

    always #2 i_sys_clk = ~i_sys_clk;

    display_window_write_commands i_display_window_write_commands (
        .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_sw_reset(sw_reset), .i_wr_valid(valid),
        .i_wr_is_data(is_data), .i_wr_data(wr_data), .i_row_column_exchange(row_column_exchange),
        .i_column_order(column_order), .i_row_order(row_order), .o_panel_output_enable(enable),
        .o_window_first_column(first_col), .o_window_last_column(last_col), .o_window_first_row(first_row),
        .o_window_last_row(last_row), .o_write_active(active), .o_mem_we(we), .o_mem_column(mem_col),
        .o_mem_row(mem_row), .o_mem_data(mem_data)
    );
    host_cmd_model i_host_cmd_model (
        .i_sys_clk(i_sys_clk), .o_valid(valid), .o_is_data(is_data), .o_data(wr_data)
    );

    // ****************************************
    // checking and closing
    // ****************************************
    task chk(input string name, input logic [17:0] seen, input logic [17:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task do_reset;
        i_arst_n = 1'b0;
        repeat (10) @(posedge i_sys_clk);
        #1 i_arst_n = 1'b1;
        repeat (3) @(posedge i_sys_clk);
        #1;
    endtask
    task px(input logic [17:0] d, input logic [15:0] col, input logic [15:0] row, input logic we_exp);
        i_host_cmd_model.put(1'b1, d);
        chk("mem we", {17'h0, we}, {17'h0, we_exp});
        if (we_exp) begin
            chk("mem column", {2'b00, mem_col}, {2'b00, col});
            chk("mem row", {2'b00, mem_row}, {2'b00, row});
            chk("mem data", mem_data, d);
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task t_reset_state;
        chk("enable", {17'h0, enable}, 18'h0);
        chk("first col", {2'b00, first_col}, 18'h0);
        chk("last col", {2'b00, last_col}, 18'h00ef);
        chk("first row", {2'b00, first_row}, 18'h0);
        chk("last row", {2'b00, last_row}, 18'h013f);
        $display("test reset_state done");
    endtask
    task t_blank;
        int k;
        for (k = 0; k < 6; k++) begin
            i_host_cmd_model.put(1'b0, {10'h000, BLANK_SEQ[47-8*k -: 8]});
            chk("enable", {17'h0, enable}, {17'h0, BLANK_SEQ[40-8*k]});
        end
        i_host_cmd_model.idle();
        $display("test blank done");
    endtask
    task t_burst;
        // a command cuts a parameter run short
        i_host_cmd_model.put(1'b0, 18'h2a);
        i_host_cmd_model.put(1'b1, 18'h00);
        i_host_cmd_model.put(1'b1, 18'h07);
        i_host_cmd_model.window(8'h2a, 16'h0002, 16'h0003);
        i_host_cmd_model.window(8'h2b, 16'h0005, 16'h0006);
        chk("first col", {2'b00, first_col}, 18'h2);
        chk("last col", {2'b00, last_col}, 18'h3);
        chk("first row", {2'b00, first_row}, 18'h5);
        chk("last row", {2'b00, last_row}, 18'h6);
        i_host_cmd_model.put(1'b0, 18'h2c);
        chk("active", {17'h0, active}, 18'h1);
        px(18'h3a001, 16'h2, 16'h5, 1'b1);
        px(18'h15002, 16'h3, 16'h5, 1'b1);
        px(18'h3a003, 16'h2, 16'h6, 1'b1);
        px(18'h15004, 16'h3, 16'h6, 1'b1);
        px(18'h3a005, 16'h2, 16'h5, 1'b1);
        column_order = 1'b1;
        row_order    = 1'b1;
        i_host_cmd_model.put(1'b0, 18'h2c);
        px(18'h2a006, 16'h3, 16'h6, 1'b1);
        px(18'h15007, 16'h2, 16'h6, 1'b1);
        i_host_cmd_model.put(1'b0, 18'h29);
        chk("active", {17'h0, active}, 18'h0);
        chk("enable", {17'h0, enable}, 18'h1);
        px(18'h2a008, 16'h0, 16'h0, 1'b0);
        column_order = 1'b0;
        row_order    = 1'b0;
        i_host_cmd_model.idle();
        $display("test burst done");
    endtask
    task t_range;
        i_host_cmd_model.window(8'h2a, 16'h00ee, 16'h00f1);
        i_host_cmd_model.window(8'h2b, 16'h0000, 16'h0000);
        i_host_cmd_model.put(1'b0, 18'h2c);
        px(18'h00111, 16'h00ee, 16'h0, 1'b1);
        px(18'h00222, 16'h00ef, 16'h0, 1'b1);
        px(18'h00333, 16'h00f0, 16'h0, 1'b0);
        row_column_exchange = 1'b1;
        px(18'h00444, 16'h00f1, 16'h0, 1'b1);
        row_column_exchange = 1'b0;
        i_host_cmd_model.idle();
        $display("test range done");
    endtask
    task t_sw_reset;
        i_host_cmd_model.put(1'b0, 18'h2c);
        i_host_cmd_model.idle();
        row_column_exchange = 1'b1;
        sw_reset            = 1'b1;
        @(posedge i_sys_clk);
        #1 sw_reset = 1'b0;
        chk("enable", {17'h0, enable}, 18'h0);
        chk("active", {17'h0, active}, 18'h0);
        chk("first col", {2'b00, first_col}, 18'h0);
        chk("last col", {2'b00, last_col}, 18'h013f);
        chk("last row", {2'b00, last_row}, 18'h00ef);
        chk("first row", {2'b00, first_row}, 18'h0);
        @(posedge i_sys_clk);
        #1 row_column_exchange = 1'b0;
        sw_reset = 1'b1;
        @(posedge i_sys_clk);
        #1 sw_reset = 1'b0;
        chk("last col", {2'b00, last_col}, 18'h00ef);
        chk("last row", {2'b00, last_row}, 18'h013f);
        $display("test sw_reset done");
    endtask

    initial begin
        do_reset();
        t_reset_state();
        t_blank();
        t_burst();
        t_range();
        t_sw_reset();
        do_reset();
        t_reset_state();
        give_verdict();
    end
    // whole run needs well under a thousand cycles
    initial begin
        #20000;
        errors++;
        give_verdict();
    end
endmodule
